// *** logic/dcpwm_regs.svh ***
`ifndef DCPWM_REGS_SVH
`define DCPWM_REGS_SVH

// ----------------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define DCPWM_IDX_Q5_SENSE     8'h58
`define DCPWM_IDX_Q6_SENSE     8'h59
`define DCPWM_IDX_PERIOD       8'h5C
`define DCPWM_IDX_SW_DELAY     8'h5D
`define DCPWM_IDX_PULSE_WIDTH  8'h5E
`define DCPWM_ADDR_W           12

// ----------------------------------------------------------------------------
// reset values and fields
// ----------------------------------------------------------------------------
`define DCPWM_PERIOD_RST       8'hFF
`define DCPWM_TOF_RST          5'h14
`define DCPWM_PW_RST           8'h00
`define DCPWM_PERIOD_FIX_BIT   6
`define DCPWM_CAL_BIT          7
`define DCPWM_RSV_BIT          6
`define DCPWM_POL_BIT          5
`define DCPWM_OFF_ADD          8'h04

// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define DCPWM_STEP_PS          61035
`define DCPWM_CLK_PERIOD_PS    10000
`define DCPWM_CAL_TIME_US      1000
`define DCPWM_CAL_CYCLES       (`DCPWM_CAL_TIME_US * 1000000 / `DCPWM_CLK_PERIOD_PS)

`endif

// *** logic/dcpwm_pkg.sv ***
package dcpwm_pkg;

    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_on   = 2'b01,
        st_off  = 2'b10,
        st_cal  = 2'b11
    } dcpwm_state_e;

    typedef logic [7:0] dcpwm_byte_t;

endpackage

// *** logic/dcpwm_tick.sv ***
`timescale 1ns/100ps
`include "dcpwm_regs.svh"

// fractional divider: one pulse per pwm time step on average, so the
// step is exact over a period while each step jitters by one clock
module dcpwm_tick #(
    parameter int STEP_PS = `DCPWM_STEP_PS,
    parameter int CLK_PS  = `DCPWM_CLK_PERIOD_PS
) (
    // clock, reset and enable
    input  wire logic clk,
    input  wire logic sys_rst,
    input  wire logic ce,
    // step pulse
    output logic      step
);

    logic [16:0] acc;
    logic [17:0] sum;

    assign sum = {1'b0, acc} + 18'(CLK_PS);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            acc  <= 17'h00000;
            step <= 1'b0;
        end else if (ce) begin
            if (sum >= 18'(STEP_PS)) begin
                acc  <= 17'(sum - 18'(STEP_PS));
                step <= 1'b1;
            end else begin
                acc  <= sum[16:0];
                step <= 1'b0;
            end
        end
    end

endmodule

// *** logic/dcpwm_core.sv ***
`timescale 1ns/100ps
`include "dcpwm_regs.svh"

// ----------------------------------------------------------------------------
// Operation
// - fifth transistor current readable as 8-bit code
// - sixth transistor current readable, same scale
// - pwm period equals period code time steps
// - period bit 6 reads one, ignores writes
// - writing calibration bit one starts calibration
// - calibration bit reads one while running
// - bit 5 reports feed-forward polarity, read-only
// - polarity zero opposite, one same as drive
// - drive off at least off code plus four
// - pulse width code is on plus off plus four
// ----------------------------------------------------------------------------
module dcpwm_core #(
    parameter int CAL_CYCLES = `DCPWM_CAL_CYCLES
) (
    // clock, reset, enable
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // analog side
    input  wire logic [7:0]  q5_current_adc,
    input  wire logic [7:0]  q6_current_adc,
    input  wire logic        peak_current_trip,
    input  wire logic        ff_same_polarity_strap,
    // converter pins
    output logic             converter_drive_pin,
    output logic             feedforward_pin,
    output logic             peak_current_cal_active
);

    localparam int CW = $clog2(CAL_CYCLES + 1);
    localparam logic [7:0] PERIOD_RST = `DCPWM_PERIOD_RST;

    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    function automatic logic [7:0] add_sat8(input logic [7:0] a,
                                            input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        add_sat8 = s[8] ? 8'hFF : s[7:0];
    endfunction

    function automatic logic is_mapped(input logic [11:0] addr);
        logic [9:0] idx;
        idx = addr[11:2];
        is_mapped = (addr[1:0] == 2'b00) &&
                    (idx == 10'(`DCPWM_IDX_Q5_SENSE) ||
                     idx == 10'(`DCPWM_IDX_Q6_SENSE) ||
                     idx == 10'(`DCPWM_IDX_PERIOD) ||
                     idx == 10'(`DCPWM_IDX_SW_DELAY) ||
                     idx == 10'(`DCPWM_IDX_PULSE_WIDTH));
    endfunction

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    dcpwm_pkg::dcpwm_state_e state;
    dcpwm_pkg::dcpwm_byte_t  fifth_transistor_current;
    dcpwm_pkg::dcpwm_byte_t  sixth_transistor_current;
    dcpwm_pkg::dcpwm_byte_t  measured_pulse_width;
    dcpwm_pkg::dcpwm_byte_t  pwm_period_code;
    logic [6:0]              period_wr;
    logic [4:0]              min_off_time_code;
    logic                    feedforward_polarity_flag;
    logic [7:0]              cur_period;
    logic [7:0]              cur_off;
    logic [7:0]              tick_cnt;
    logic [7:0]              on_cnt;
    logic [CW-1:0]           cal_cnt;
    logic                    step;
    logic [9:0]              idx;
    logic                    wr_en;
    logic                    rd_setup;
    logic                    peak_current_cal_go;
    logic                    period_end;
    logic [7:0]              next_off;
    logic                    stay_on;

    dcpwm_tick dcpwm_tick_i (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .step    (step)
    );

    // ------------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------------
    assign idx      = paddr[11:2];
    assign pready   = ce;
    assign pslverr  = psel && penable && !is_mapped(paddr);
    assign wr_en    = ce && psel && penable && pwrite && is_mapped(paddr);
    assign rd_setup = ce && psel && !penable && !pwrite;

    // bit 6 is not stored, it is wired high
    assign pwm_period_code = {period_wr[6], 1'b1, period_wr[5:0]};

    assign peak_current_cal_go = wr_en &&
        idx == 10'(`DCPWM_IDX_SW_DELAY) &&
        pwdata[`DCPWM_CAL_BIT];

    // ------------------------------------------------------------------------
    // sense capture
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            fifth_transistor_current <= 8'h00;
            sixth_transistor_current <= 8'h00;
        end else if (ce) begin
            fifth_transistor_current <= q5_current_adc;
            sixth_transistor_current <= q6_current_adc;
        end
    end

    // variant strap is caught while reset is held
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            feedforward_polarity_flag <= ff_same_polarity_strap;
        end
    end

    // ------------------------------------------------------------------------
    // writable fields
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            period_wr         <= {PERIOD_RST[7], PERIOD_RST[5:0]};
            min_off_time_code <= `DCPWM_TOF_RST;
        end else if (wr_en) begin
            if (idx == 10'(`DCPWM_IDX_PERIOD)) begin
                period_wr <= {pwdata[7], pwdata[5:0]};
            end
            if (idx == 10'(`DCPWM_IDX_SW_DELAY)) begin
                min_off_time_code <= pwdata[4:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // read data, latched in the setup phase so the answer is a flop
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= 32'h00000000;
            case (idx)
                10'(`DCPWM_IDX_Q5_SENSE): begin
                    prdata[7:0] <= fifth_transistor_current;
                end
                10'(`DCPWM_IDX_Q6_SENSE): begin
                    prdata[7:0] <= sixth_transistor_current;
                end
                10'(`DCPWM_IDX_PERIOD): begin
                    prdata[7:0] <= pwm_period_code;
                end
                10'(`DCPWM_IDX_SW_DELAY): begin
                    prdata[`DCPWM_CAL_BIT] <= (state == dcpwm_pkg::st_cal);
                    prdata[`DCPWM_RSV_BIT] <= 1'b0;
                    prdata[`DCPWM_POL_BIT] <= feedforward_polarity_flag;
                    prdata[4:0]            <= min_off_time_code;
                end
                10'(`DCPWM_IDX_PULSE_WIDTH): begin
                    prdata[7:0] <= measured_pulse_width;
                end
                default: begin
                    prdata <= 32'h00000000;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // pwm sequencer
    // ------------------------------------------------------------------------
    // new period settings are only taken at a period boundary, so a write
    // without the calibration bit never produces a truncated or stretched cycle
    assign next_off   = 8'(min_off_time_code) + `DCPWM_OFF_ADD;
    assign period_end = step && (tick_cnt == cur_period - 8'h01);
    // stay on for the next step only if the rest still fits the off time
    assign stay_on    = !peak_current_trip &&
                        ({1'b0, tick_cnt} + 9'h002 + {1'b0, cur_off}
                         <= {1'b0, cur_period});

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state                <= dcpwm_pkg::st_idle;
            cur_period           <= `DCPWM_PERIOD_RST;
            cur_off              <= 8'(`DCPWM_TOF_RST) + `DCPWM_OFF_ADD;
            tick_cnt             <= 8'h00;
            on_cnt               <= 8'h00;
            measured_pulse_width <= `DCPWM_PW_RST;
            cal_cnt              <= '0;
        end else if (ce) begin
            if (peak_current_cal_go && state != dcpwm_pkg::st_cal) begin
                state   <= dcpwm_pkg::st_cal;
                cal_cnt <= CW'(CAL_CYCLES - 1);
            end else begin
                case (state)
                    dcpwm_pkg::st_idle: begin
                        if (step) begin
                            cur_period <= pwm_period_code;
                            cur_off    <= next_off;
                            tick_cnt   <= 8'h00;
                            on_cnt     <= 8'h00;
                            if (next_off + 8'h01 <= pwm_period_code) begin
                                state <= dcpwm_pkg::st_on;
                            end else begin
                                state <= dcpwm_pkg::st_off;
                            end
                        end
                    end
                    dcpwm_pkg::st_on: begin
                        if (step) begin
                            tick_cnt <= tick_cnt + 8'h01;
                            on_cnt   <= on_cnt + 8'h01;
                            if (!stay_on) begin
                                state <= dcpwm_pkg::st_off;
                            end
                        end
                    end
                    dcpwm_pkg::st_off: begin
                        if (period_end) begin
                            measured_pulse_width <=
                                add_sat8(on_cnt, cur_off);
                            cur_period <= pwm_period_code;
                            cur_off    <= next_off;
                            tick_cnt   <= 8'h00;
                            on_cnt     <= 8'h00;
                            if (next_off + 8'h01 <= pwm_period_code) begin
                                state <= dcpwm_pkg::st_on;
                            end
                        end else if (step) begin
                            tick_cnt <= tick_cnt + 8'h01;
                        end
                    end
                    dcpwm_pkg::st_cal: begin
                        if (cal_cnt == '0) begin
                            // a whole off period first, so a pulse cut by
                            // calibration never shortens the off time
                            state    <= dcpwm_pkg::st_off;
                            tick_cnt <= 8'h00;
                            on_cnt   <= 8'h00;
                        end else begin
                            cal_cnt <= cal_cnt - CW'(1);
                        end
                    end
                    default: begin
                        state <= dcpwm_pkg::st_idle;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------------
    // pins
    // ------------------------------------------------------------------------
    assign converter_drive_pin     = (state == dcpwm_pkg::st_on);
    assign peak_current_cal_active = (state == dcpwm_pkg::st_cal);
    assign feedforward_pin = feedforward_polarity_flag ?
        converter_drive_pin : !converter_drive_pin;

    // ------------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------------
    logic [7:0] off_ticks;
    logic [7:0] off_req;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            off_ticks <= 8'hFF;
            off_req   <= 8'h00;
        end else if (ce) begin
            if (state == dcpwm_pkg::st_on && !stay_on && step) begin
                off_ticks <= 8'h00;
                off_req   <= cur_off;
            end else if (step && !converter_drive_pin &&
                         off_ticks != 8'hFF) begin
                off_ticks <= off_ticks + 8'h01;
            end
        end
    end

    property p_q5_sense;
        @(posedge clk) disable iff (sys_rst)
        ce |=> fifth_transistor_current == $past(q5_current_adc);
    endproperty
    a_q5_sense: assert property (p_q5_sense)
        else $error("fifth transistor current not captured");

    property p_q6_read;
        @(posedge clk) disable iff (sys_rst)
        (rd_setup && idx == 10'(`DCPWM_IDX_Q6_SENSE))
        |=> prdata == {24'h000000, $past(sixth_transistor_current)};
    endproperty
    a_q6_read: assert property (p_q6_read)
        else $error("sixth transistor current read wrong");

    property p_period_wrap;
        @(posedge clk) disable iff (sys_rst)
        (ce && period_end && state == dcpwm_pkg::st_off)
        |=> tick_cnt == 8'h00 && cur_period == $past(pwm_period_code);
    endproperty
    a_period_wrap: assert property (p_period_wrap)
        else $error("period did not restart at its code");

    property p_period_fixed;
        @(posedge clk) disable iff (sys_rst)
        (rd_setup && idx == 10'(`DCPWM_IDX_PERIOD)) |=> prdata[6];
    endproperty
    a_period_fixed: assert property (p_period_fixed)
        else $error("period bit 6 not one");

    property p_cal_start;
        @(posedge clk) disable iff (sys_rst)
        peak_current_cal_go |=> peak_current_cal_active
            && !converter_drive_pin;
    endproperty
    a_cal_start: assert property (p_cal_start)
        else $error("calibration did not start");

    property p_cal_read;
        @(posedge clk) disable iff (sys_rst)
        (rd_setup && idx == 10'(`DCPWM_IDX_SW_DELAY))
        |=> prdata[7] == $past(peak_current_cal_active) && !prdata[6];
    endproperty
    a_cal_read: assert property (p_cal_read)
        else $error("calibration status or reserved bit wrong");

    property p_polarity;
        @(posedge clk) disable iff (sys_rst)
        (rd_setup && idx == 10'(`DCPWM_IDX_SW_DELAY))
        |=> prdata[5] == (feedforward_pin == converter_drive_pin);
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("polarity flag disagrees with pins");

    property p_min_off;
        @(posedge clk) disable iff (sys_rst)
        $rose(converter_drive_pin) && off_ticks != 8'hFF
        |-> off_ticks >= off_req;
    endproperty
    a_min_off: assert property (p_min_off)
        else $error("minimum off time violated");

    property p_pulse_width;
        @(posedge clk) disable iff (sys_rst)
        (ce && period_end && state == dcpwm_pkg::st_off)
        |=> measured_pulse_width == add_sat8($past(on_cnt), $past(cur_off));
    endproperty
    a_pulse_width: assert property (p_pulse_width)
        else $error("pulse width code wrong");

    property p_cal_done;
        @(posedge clk) disable iff (sys_rst)
        (ce && state == dcpwm_pkg::st_cal && cal_cnt == '0
         && !peak_current_cal_go) |=> !peak_current_cal_active;
    endproperty
    a_cal_done: assert property (p_cal_done)
        else $error("calibration bit did not clear");

endmodule

// *** testbench/dcpwm_far_side.sv ***
`timescale 1ns/100ps

// switching transistor and sense comparator; it also times the drive
// phases so the bench can compare them with the programmed codes
module dcpwm_far_side (
    // clock
    input  wire logic        clk,
    // converter pins
    input  wire logic        converter_drive_pin,
    input  wire logic        feedforward_pin,
    // trip once the run count reaches this many clocks while driven (the first driven clock still sees the off run), zero never trips
    input  wire logic [15:0] trip_after,
    output logic             peak_current_trip,
    // last complete phases, in clocks
    output int               on_clks,
    output int               off_clks,
    output int               per_clks
);
    int   run;
    logic drv_q;

    initial begin
        run = 0;
        drv_q = 1'b0;
        on_clks = 0;
        off_clks = 0;
        per_clks = 0;
        peak_current_trip = 1'b0;
    end

    always @(posedge clk) begin
        drv_q <= converter_drive_pin;
        run <= (converter_drive_pin != drv_q) ? 1 : run + 1;
        if (converter_drive_pin && !drv_q) begin
            off_clks <= run;
            per_clks <= run + on_clks;
        end
        if (!converter_drive_pin && drv_q) begin
            on_clks <= run;
        end
        // current ramps while on; comparator releases once switched off
        peak_current_trip <= converter_drive_pin && (trip_after != 16'h0000)
                             && (run >= int'(trip_after));
    end
endmodule

// *** testbench/dcdc_pwm_control_regs_bench.sv ***
`timescale 1ns/100ps
`include "dcpwm_regs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_errors++; \
$display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end

module dcdc_pwm_control_regs_bench;
    typedef struct {
        logic [7:0] idx, wd, adc, exp;
        logic       wr;
    } dcpwm_row_s;
    typedef struct {
        logic [7:0]  per;
        logic [4:0]  tof;
        logic [15:0] trip;
    } dcpwm_case_s;

    logic        clk, sys_rst, ce, psel, penable, pwrite, strap;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, drv, ff, cal_active, trip;
    logic [7:0]  q5, q6;
    logic [15:0] trip_after;
    int          on_clks, off_clks, per_clks, n_errors, comparisons, cycles;
    int          n, e;

    // ------------------------------------------------------------------
    // ordinary register cases: optional write, then read back
    // ------------------------------------------------------------------
    dcpwm_row_s rows [9] = '{
        '{`DCPWM_IDX_PERIOD, 8'h00, 8'h00, 8'h40, 1'b1},
        '{`DCPWM_IDX_PERIOD, 8'h80, 8'h00, 8'hC0, 1'b1},
        '{`DCPWM_IDX_PERIOD, 8'h3F, 8'h00, 8'h7F, 1'b1},
        '{`DCPWM_IDX_SW_DELAY, 8'h7F, 8'h00, 8'h1F, 1'b1},
        '{`DCPWM_IDX_SW_DELAY, 8'h14, 8'h00, 8'h14, 1'b1},
        '{`DCPWM_IDX_Q5_SENSE, 8'h00, 8'hFF, 8'hFF, 1'b0},
        '{`DCPWM_IDX_Q5_SENSE, 8'hFF, 8'h00, 8'h00, 1'b1},
        '{`DCPWM_IDX_Q6_SENSE, 8'h00, 8'h3C, 8'hC3, 1'b0},
        '{`DCPWM_IDX_Q6_SENSE, 8'h00, 8'hFF, 8'h00, 1'b1}};
    // short range, long range, and a tripped pulse
    dcpwm_case_s cases [3] = '{'{8'h40, 5'h00, 16'h0000},
        '{8'hFF, 5'h1F, 16'h0000}, '{8'hC0, 5'h14, 16'h012C}};

    dcpwm_core #(.CAL_CYCLES(20)) dcpwm_core_i (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .q5_current_adc(q5), .q6_current_adc(q6),
        .peak_current_trip(trip), .ff_same_polarity_strap(strap),
        .converter_drive_pin(drv), .feedforward_pin(ff),
        .peak_current_cal_active(cal_active));

    dcpwm_far_side dcpwm_far_side_i (
        .clk(clk), .converter_drive_pin(drv), .feedforward_pin(ff),
        .trip_after(trip_after), .peak_current_trip(trip),
        .on_clks(on_clks), .off_clks(off_clks), .per_clks(per_clks));

    always #5 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            n_errors++;
            wrap_up();
        end
    end

    function automatic logic near(int a, int b, int tol);
        return (a - b <= tol) && (b - a <= tol);
    endfunction

    function automatic int clks(int steps);
        return steps * `DCPWM_STEP_PS / `DCPWM_CLK_PERIOD_PS;
    endfunction

    // entered right after a rising edge; waits for pready, no fixed count
    task automatic apb(input logic wr, input logic [7:0] idx,
                       input logic [7:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never re-drives psel at once
        @(posedge clk);
    endtask

    task automatic do_reset(input logic s);
        strap <= s;
        sys_rst <= 1'b1;
        repeat (12) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    initial begin
        clk = 0; sys_rst = 1; ce = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; q5 = 0; q6 = 0; strap = 0;
        trip_after = 0; n_errors = 0; comparisons = 0; cycles = 0;
        @(posedge clk);
        do_reset(1'b0);
        apb(1'b0, `DCPWM_IDX_PERIOD, 8'h00);
        `CHK(rd, 32'h000000FF)
        apb(1'b0, `DCPWM_IDX_SW_DELAY, 8'h00);
        `CHK(rd, 32'h00000014)
        apb(1'b0, `DCPWM_IDX_PULSE_WIDTH, 8'h00);
        `CHK(rd, 32'h00000000)
        `CHK(ff, ~drv)
        $display("test reset done");
        foreach (rows[i]) begin
            q5 <= rows[i].adc;
            q6 <= ~rows[i].adc;
            // the sense register trails its input by one clock
            @(posedge clk);
            if (rows[i].wr) apb(1'b1, rows[i].idx, rows[i].wd);
            apb(1'b0, rows[i].idx, 8'h00);
            `CHK(rd, {24'h000000, rows[i].exp})
        end
        apb(1'b0, 8'h5A, 8'h00);
        `CHK({err, rd}, 33'h100000000)
        $display("test registers done");
        // --------------------------------------------------------------
        // pwm timing, measured at the pins by the far side
        // --------------------------------------------------------------
        foreach (cases[i]) begin
            trip_after <= cases[i].trip;
            apb(1'b1, `DCPWM_IDX_PERIOD, cases[i].per);
            apb(1'b1, `DCPWM_IDX_SW_DELAY, {3'b000, cases[i].tof});
            repeat (3) @(posedge drv);
            apb(1'b0, `DCPWM_IDX_PULSE_WIDTH, 8'h00);
            e = int'(cases[i].tof) + 4;
            `CHK(near(per_clks, clks(int'(cases[i].per)), 1), 1'b1)
            if (cases[i].trip == 16'h0000) begin
                `CHK(rd[7:0], cases[i].per)
                `CHK(near(off_clks, clks(e), 1), 1'b1)
            end else begin
                `CHK(near(on_clks, clks(int'(rd[7:0]) - e), 2), 1'b1)
                `CHK(off_clks >= clks(e) - 1, 1'b1)
            end
        end
        trip_after <= 16'h0000;
        $display("test pwm done");
        apb(1'b1, `DCPWM_IDX_SW_DELAY, 8'h94);
        apb(1'b0, `DCPWM_IDX_SW_DELAY, 8'h00);
        `CHK(rd, 32'h00000094)
        `CHK({cal_active, drv}, 2'b10)
        n = 0;
        while (cal_active === 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        `CHK(n < 20, 1'b1)
        apb(1'b0, `DCPWM_IDX_SW_DELAY, 8'h00);
        `CHK(rd, 32'h00000014)
        $display("test calibration done");
        ce <= 1'b0;
        @(posedge clk);
        e = int'(drv);
        repeat (50) @(posedge clk);
        `CHK({pready, drv}, {1'b0, e[0]})
        ce <= 1'b1;
        $display("test enable done");
        do_reset(1'b1);
        apb(1'b0, `DCPWM_IDX_SW_DELAY, 8'h00);
        `CHK(rd, 32'h00000034)
        repeat (2) @(posedge drv);
        n = 0;
        repeat (400) begin
            @(negedge clk);
            if (ff !== drv) n++;
        end
        `CHK(n, 0)
        $display("test polarity done");
        wrap_up();
    end
endmodule
